// ### verification/pin_world.sv
// Board-side model of the eight port A pads.
// Assumes the bench sets what the board drives onto released pads.
`timescale 1ns/1ps
`default_nettype none

module pin_world (
	// Port side
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe_n,
	// Board side
	input  wire logic [7:0] board,
	output logic [7:0]      pin_in
);
	// The board only shows where the port has let go of the pad
	assign pin_in = (pin_out & ~pin_oe_n) | (board & pin_oe_n);
endmodule

`default_nettype wire

// ### verification/port_a_gpio_bench.sv
// Self-checking bench for port A: registers over AXI4-Lite, pads, feeds.
// Assumes pin_world stands on the pads; all stimulus on rising aclk.
`timescale 1ns/1ps
`default_nettype none

module port_a_gpio_bench;
	localparam logic [11:0] A_PIN = port_a_pkg::ADDR_PIN_LEVELS;
	localparam logic [11:0] A_DIR = port_a_pkg::ADDR_DIRECTION;
	localparam logic [11:0] A_LAT = port_a_pkg::ADDR_OUT_LATCH;
	localparam logic [11:0] A_CFG = port_a_pkg::ADDR_CONFIG;
	logic        aclk, aresetn;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, v;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [7:0]  pin_in, pin_out, pin_oe_n, board;
	logic        sck_o, sck_d, sdt_o, sdt_d, sck_i, sdt_i;
	logic        irq0, irq1, chg0, chg1, cnt0, fault, slow_ck, master_clear_n_n;
	int          bad_count, compares;

	port_a_gpio DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.serial_sync_clock_out(sck_o), .serial_sync_clock_drive(sck_d),
		.serial_sync_data_out(sdt_o), .serial_sync_data_drive(sdt_d),
		.serial_sync_clock_in(sck_i), .serial_sync_data_in(sdt_i),
		.ext_irq_zero(irq0), .ext_irq_one(irq1),
		.change_irq_zero(chg0), .change_irq_one(chg1),
		.counter0_clock_in(cnt0), .pwm_fault_input(fault),
		.slow_counter_clock_in(slow_ck), .master_clear_n(master_clear_n_n));

	pin_world pads (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.board(board), .pin_in(pin_in));

	always #10 aclk = ~aclk;

	// *****
	// Compare and bus tasks
	// *****
	task automatic cmp_w(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("Error at %0t: word %h expected %h", $time, g, e);
		end
	endtask

	task automatic cmp_b(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("Error at %0t: pins %b expected %b", $time, g, e);
		end
	endtask

	function automatic logic [31:0] rsp(input logic [11:0] a);
		return (a > A_CFG) ? 32'h2 : 32'h0;
	endfunction

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic da, dw;
		da = 0;
		dw = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(da && dw)) begin
			@(negedge aclk);
			if (awvalid && awready) da = 1;
			if (wvalid && wready) dw = 1;
			@(posedge aclk);
			if (da) awvalid <= 0;
			if (dw) wvalid <= 0;
		end
		@(negedge aclk);
		while (!bvalid) @(negedge aclk);
		cmp_w({30'h0, bresp}, rsp(a));
		@(posedge aclk);
		bready <= 0;
	endtask

	task automatic chk(input logic [11:0] a, input logic [31:0] e);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		@(negedge aclk);
		while (!arready) @(negedge aclk);
		@(posedge aclk);
		arvalid <= 0;
		@(negedge aclk);
		while (!rvalid) @(negedge aclk);
		v = rdata;
		cmp_w({30'h0, rresp}, rsp(a));
		cmp_w(v, e);
		@(posedge aclk);
		rready <= 0;
	endtask

	// Feeds lag the pads by three cycles
	task automatic pins(input logic [7:0] b);
		@(posedge aclk);
		board <= b;
		repeat (4) @(negedge aclk);
	endtask

	// *****
	// Scenarios
	// *****
	task automatic t_reset;
		cmp_b(pin_oe_n, 8'hff);
		chk(A_DIR, 32'hff);
		chk(A_LAT, 32'h0);
		chk(A_CFG, 32'h3307);
		chk(A_PIN, 32'hcc);
	endtask

	task automatic t_drive;
		wr(A_CFG, 32'h7);
		wr(A_PIN, 32'h5a);
		wr(A_DIR, 32'h0);
		pins(8'hff);
		cmp_b(pin_out, 8'h5a);
		cmp_b(pin_oe_n, 8'h20);
		chk(A_PIN, 32'h7a);
		chk(A_LAT, 32'h5a);
		wr(A_DIR, 32'hff);
		pins(8'ha5);
		chk(A_PIN, 32'ha5);
		chk(A_LAT, 32'h5a);
	endtask

	task automatic t_osc;
		logic [7:0] e;
		pins(8'hff);
		for (int m = 0; m < 8; m++) begin
			e = {m >= 6, (m == 3 || m == 5 || m == 7), 6'h3f};
			wr(A_CFG, 32'(m));
			pins(8'hff);
			chk(A_DIR, {24'h0, e});
			chk(A_PIN, {24'h0, e});
			chk(A_LAT, {24'h0, e & 8'h5a});
		end
	endtask

	task automatic t_analog;
		wr(A_CFG, 32'h107);
		wr(A_LAT, 32'h5);
		wr(A_DIR, 32'hfe);
		pins(8'hff);
		cmp_b({6'h0, pin_oe_n[0], pin_out[0]}, 8'h1);
		wr(A_DIR, 32'hff);
		chk(A_PIN, 32'hfe);
		wr(A_CFG, 32'h47);
		wr(A_DIR, 32'hfb);
		pins(8'hff);
		cmp_b(pin_oe_n, 8'hff);
		chk(A_PIN, 32'hfb);
	endtask

	task automatic t_fault;
		wr(A_CFG, 32'h7);
		pins(8'h20);
		cmp_b({6'h0, fault, master_clear_n_n}, 8'h3);
		wr(A_CFG, 32'hf);
		pins(8'h20);
		cmp_b({6'h0, fault, master_clear_n_n}, 8'h1);
		pins(8'h80);
		cmp_b({6'h0, fault, master_clear_n_n}, 8'h2);
	endtask

	task automatic t_slow;
		wr(A_LAT, 32'h0);
		wr(A_DIR, 32'h0);
		wr(A_CFG, 32'h37);
		pins(8'hc0);
		cmp_b(pin_oe_n, 8'he0);
		chk(A_PIN, 32'h0);
		pins(8'h40);
		cmp_b({7'h0, slow_ck}, 8'h1);
		wr(A_CFG, 32'h27);
		pins(8'h40);
		cmp_b({7'h0, slow_ck}, 8'h0);
	endtask

	task automatic t_feeds;
		wr(A_CFG, 32'h7);
		wr(A_DIR, 32'hff);
		pins(8'h03);
		cmp_b({3'h0, irq0, chg0, irq1, chg1, cnt0}, 8'h1e);
		pins(8'h10);
		cmp_b({3'h0, irq0, chg0, irq1, chg1, cnt0}, 8'h01);
	endtask

	task automatic t_serial;
		wr(A_CFG, 32'h87);
		@(posedge aclk);
		sck_o <= 1;
		sck_d <= 1;
		pins(8'h08);
		cmp_b({2'h0, pin_oe_n[3], pin_out[3], pin_oe_n[2], pin_out[2],
			sck_i, sdt_i}, 8'h27);
		@(posedge aclk);
		sck_o <= 0;
		sdt_o <= 1;
		sdt_d <= 1;
		pins(8'h00);
		cmp_b({2'h0, pin_oe_n[3], pin_out[3], pin_oe_n[2], pin_out[2],
			sck_i, sdt_i}, 8'h11);
	endtask

	task automatic t_unmapped;
		wr(12'h010, 32'h0);
		chk(12'h010, 32'h0);
		chk(A_DIR, 32'hff);
	endtask

	task conclude;
		$display("Mismatches %0d, comparisons %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		aclk = 0;
		aresetn = 0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{sck_o, sck_d, sdt_o, sdt_d} = '0;
		board = 8'hff;
		bad_count = 0;
		compares = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		t_reset;
		t_drive;
		t_osc;
		t_analog;
		t_fault;
		t_slow;
		t_feeds;
		t_serial;
		t_unmapped;
		conclude;
	end

	// Whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge aclk);
		bad_count++;
		conclude;
	end
endmodule

`default_nettype wire

// ### verilog/pin_sync.sv
// Two-flop synchroniser for the eight pin levels.
// Assumes pin levels are asynchronous to aclk.
`timescale 1ns/1ps
`default_nettype none

module pin_sync (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Pin levels
	pin_sync_if.sync  ps
);
	logic [7:0] stage1_r;
	logic [7:0] stage2_r;

	// First stage feeds only the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage1_r <= 8'h00;
			stage2_r <= 8'h00;
		end else begin
			stage1_r <= ps.raw;
			stage2_r <= stage1_r;
		end
	end

	assign ps.synced = stage2_r;

endmodule

`default_nettype wire

// ### verilog/pin_sync_if.sv
// Raw and synchronised pin levels between the port core and its
// synchroniser. Assumes both ends run on the core clock.
`timescale 1ns/1ps
`default_nettype none

interface pin_sync_if;
	logic [7:0] raw;
	logic [7:0] synced;
	modport core (output raw, input synced);
	modport sync (input raw, output synced);
endinterface

`default_nettype wire

// ### verilog/port_a_gpio.sv
// Port A: direction, pin-level and output latch registers over AXI4-Lite,
// pin drive and oscillator, analog and serial overrides.
// Assumes pins are asynchronous to aclk; the serial port runs on aclk.
`timescale 1ns/1ps
`default_nettype none

module port_a_gpio (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Pins
	input  wire logic [7:0]  pin_in,
	output logic [7:0]       pin_out,
	output logic [7:0]       pin_oe_n,
	// Serial port drive for pins 2 and 3
	input  wire logic        serial_sync_clock_out,
	input  wire logic        serial_sync_clock_drive,
	input  wire logic        serial_sync_data_out,
	input  wire logic        serial_sync_data_drive,
	// Peripheral feeds
	output logic             serial_sync_clock_in,
	output logic             serial_sync_data_in,
	output logic             ext_irq_zero,
	output logic             ext_irq_one,
	output logic             change_irq_zero,
	output logic             change_irq_one,
	output logic             counter0_clock_in,
	output logic             pwm_fault_input,
	output logic             slow_counter_clock_in,
	output logic             master_clear_n
);

	// ****************************************
	// Registers and synchroniser
	// ****************************************
	logic [7:0]  dir_r;
	logic [7:0]  latch_r;
	logic [15:0] cfg_r;
	logic [11:0] awaddr_r;
	logic        aw_held_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic        w_held_r;
	logic        do_write;

	pin_sync_if ps ();

	assign ps.raw = pin_in;

	pin_sync u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ps      (ps)
	);

	// ****************************************
	// Pin role decode
	// ****************************************
	port_a_pkg::osc_mode_e osc_mode;
	logic [7:0]            analog_sel;
	logic [7:0]            port_pin;
	logic [7:0]            slow_pins;
	logic [7:0]            dig_in_ok;
	logic [7:0]            dig_out_ok;
	logic [7:0]            serial_own;
	logic                  pin6_io;
	logic                  pin7_io;

	assign osc_mode   = port_a_pkg::osc_mode_e'(cfg_r[2:0]);
	assign analog_sel = cfg_r[15:8] & port_a_pkg::ANALOG_CAPABLE;

	always_comb begin
		pin6_io = (osc_mode == port_a_pkg::OSC_RC_OSC_WITH_IO) ||
			(osc_mode == port_a_pkg::OSC_INTERNAL_OSC_WITH_IO) ||
			(osc_mode == port_a_pkg::OSC_EXT_CLOCK_WITH_IO);
		// RC and external clock modes need the input pin
		pin7_io = (osc_mode == port_a_pkg::OSC_INT_CLK_OUT) ||
			(osc_mode == port_a_pkg::OSC_INTERNAL_OSC_WITH_IO);
	end

	assign port_pin = {pin7_io, pin6_io, 6'h3f};
	// Slow oscillator lands on pins 6/7 only when its select is set
	assign slow_pins = (cfg_r[port_a_pkg::CFG_SLOW_EN] &&
		cfg_r[port_a_pkg::CFG_SLOW_SEL]) ? 8'hc0 : 8'h00;
	assign serial_own = cfg_r[port_a_pkg::CFG_SERIAL_EN] ?
		8'h0c : 8'h00;

	always_comb begin
		dig_in_ok  = port_pin & ~analog_sel & ~slow_pins;
		dig_out_ok = port_pin & ~slow_pins & 8'hdf;
		if (cfg_r[port_a_pkg::CFG_COMPARATOR_REF_OUT_EN]) begin
			dig_in_ok[2]  = 1'b0;
			dig_out_ok[2] = 1'b0;
		end
	end

	// ****************************************
	// Read views
	// ****************************************
	logic [7:0] pin_rd;
	logic [7:0] dir_rd;
	logic [7:0] lat_rd;

	assign pin_rd = ps.synced & dig_in_ok;
	assign dir_rd = dir_r & port_pin;
	assign lat_rd = latch_r & port_pin;

	function automatic logic [31:0] read_word(input logic [11:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (a)
			port_a_pkg::ADDR_PIN_LEVELS: v[7:0]  = pin_rd;
			port_a_pkg::ADDR_DIRECTION:  v[7:0]  = dir_rd;
			port_a_pkg::ADDR_OUT_LATCH:  v[7:0]  = lat_rd;
			port_a_pkg::ADDR_CONFIG:     v[15:0] = cfg_r;
			default:                     v       = 32'h0000_0000;
		endcase
		return v;
	endfunction

	function automatic logic mapped(input logic [11:0] a);
		return (a == port_a_pkg::ADDR_PIN_LEVELS) ||
			(a == port_a_pkg::ADDR_DIRECTION) ||
			(a == port_a_pkg::ADDR_OUT_LATCH) ||
			(a == port_a_pkg::ADDR_CONFIG);
	endfunction

	// ****************************************
	// AXI4-Lite write channel
	// ****************************************
	assign s_axi_awready = !aw_held_r;
	assign s_axi_wready  = !w_held_r;
	assign do_write      = aw_held_r && w_held_r && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			awaddr_r  <= 12'h000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_r <= 1'b1;
			awaddr_r  <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			wdata_r  <= 32'h0000_0000;
			wstrb_r  <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_r <= 1'b1;
			wdata_r  <= s_axi_wdata;
			wstrb_r  <= s_axi_wstrb;
		end else if (do_write) begin
			w_held_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= port_a_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= mapped(awaddr_r) ? port_a_pkg::RESP_OKAY :
				port_a_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ****************************************
	// Register updates
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			latch_r <= port_a_pkg::LATCH_RESET;
		end else if (do_write && wstrb_r[0] &&
			(awaddr_r == port_a_pkg::ADDR_PIN_LEVELS ||
			awaddr_r == port_a_pkg::ADDR_OUT_LATCH)) begin
			latch_r <= wdata_r[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dir_r <= port_a_pkg::DIR_RESET;
		end else if (do_write && wstrb_r[0] &&
			awaddr_r == port_a_pkg::ADDR_DIRECTION) begin
			dir_r <= wdata_r[7:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_r <= {port_a_pkg::ANALOG_RESET,
				port_a_pkg::CFG_LOW_RESET};
		end else if (do_write &&
			awaddr_r == port_a_pkg::ADDR_CONFIG) begin
			if (wstrb_r[0]) begin
				cfg_r[7:0] <= wdata_r[7:0];
			end
			if (wstrb_r[1]) begin
				cfg_r[15:8] <= wdata_r[15:8];
			end
		end
	end

	// ****************************************
	// AXI4-Lite read channel
	// ****************************************
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= port_a_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= read_word(s_axi_araddr);
			s_axi_rresp  <= mapped(s_axi_araddr) ?
				port_a_pkg::RESP_OKAY : port_a_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ****************************************
	// Pin drive
	// ****************************************
	// Analog selection leaves the output path alone; direction rules it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_out  <= 8'h00;
			pin_oe_n <= 8'hff;
		end else begin
			for (int i = 0; i < 8; i++) begin
				pin_out[i]  <= latch_r[i];
				pin_oe_n[i] <= dir_r[i] || !dig_out_ok[i];
			end
			if (serial_own[2]) begin
				pin_out[2]  <= serial_sync_clock_out;
				pin_oe_n[2] <= !serial_sync_clock_drive ||
					!dig_out_ok[2];
			end
			if (serial_own[3]) begin
				pin_out[3]  <= serial_sync_data_out;
				pin_oe_n[3] <= !serial_sync_data_drive;
			end
		end
	end

	// ****************************************
	// Peripheral feeds
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_irq_zero          <= 1'b0;
			ext_irq_one           <= 1'b0;
			change_irq_zero       <= 1'b0;
			change_irq_one        <= 1'b0;
			serial_sync_clock_in  <= 1'b0;
			serial_sync_data_in   <= 1'b0;
			counter0_clock_in     <= 1'b0;
			pwm_fault_input       <= 1'b0;
			slow_counter_clock_in <= 1'b0;
			master_clear_n        <= 1'b1;
		end else begin
			ext_irq_zero          <= ps.synced[0];
			change_irq_zero       <= ps.synced[0];
			ext_irq_one           <= ps.synced[1];
			change_irq_one        <= ps.synced[1];
			serial_sync_clock_in  <= ps.synced[2] & serial_own[2];
			serial_sync_data_in   <= ps.synced[3] & serial_own[3];
			counter0_clock_in     <= ps.synced[4];
			pwm_fault_input       <= cfg_r[port_a_pkg::CFG_FAULT_SEL] ?
				ps.synced[7] : ps.synced[5];
			master_clear_n        <= ps.synced[5];
			slow_counter_clock_in <= cfg_r[port_a_pkg::CFG_SLOW_SEL] &
				ps.synced[6];
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence latch_write_s;
		do_write && wstrb_r[0] &&
			awaddr_r == port_a_pkg::ADDR_PIN_LEVELS;
	endsequence

	sequence plain_out3_s;
		!dir_r[3] && !serial_own[3] && dig_out_ok[3];
	endsequence

	input_hiz_a: assert property (dir_r[1] |=> pin_oe_n[1])
		else $error("input pin is driven");
	latch_drive_a: assert property (plain_out3_s |=> !pin_oe_n[3] &&
		pin_out[3] == $past(latch_r[3]))
		else $error("output pin not driven from latch");
	pin_write_a: assert property (latch_write_s |=>
		lat_rd[5:0] == $past(wdata_r[5:0]))
		else $error("pin-level write missed the latch");
	osc_pins_zero_a: assert property (!pin6_io |-> !pin_rd[6] &&
		!dir_rd[6] && !lat_rd[6])
		else $error("oscillator pin reads nonzero");
	pin7_ext_osc_a: assert property (!pin7_io |=> pin_oe_n[7])
		else $error("pin 7 driven in external oscillator mode");
	analog_in_zero_a: assert property (analog_sel[0] |-> !pin_rd[0])
		else $error("analog pin reads digital level");
	comparator_ref_out_pin2_a: assert property (cfg_r[port_a_pkg::CFG_COMPARATOR_REF_OUT_EN] |=>
		pin_oe_n[2] && !$past(pin_rd[2]))
		else $error("pin 2 active under reference output");
	pin5_input_a: assert property (pin_oe_n[5])
		else $error("pin 5 driven");
	slow_osc_in_a: assert property (slow_pins[6] |=>
		pin_oe_n[6] && pin_oe_n[7])
		else $error("slow oscillator pin driven");
	fault_route_a: assert property (!cfg_r[port_a_pkg::CFG_FAULT_SEL]
		##1 !cfg_r[port_a_pkg::CFG_FAULT_SEL] |->
		pwm_fault_input == $past(ps.synced[5]))
		else $error("fault input on wrong pin");
	// Synchroniser output equals the pin levels of two cycles before
	sync_depth_a: assert property ($past(aresetn, 2) |-> ps.synced ==
		$past(pin_in, 2))
		else $error("pin sample not two cycles deep");

endmodule

`default_nettype wire

// ### verilog/port_a_pkg.sv
// Constants, encodings and register map of the eight-bit port A block.
// Assumes an AXI4-Lite master on a 50 MHz core clock; nothing else.
//
// Operation
// - Eight pin bits, each but pin 5 an input or an output on its own.
// - Direction bit 1 puts the pin driver in high impedance.
// - Direction bit 0 drives the pin from its output latch bit.
// - Pin-level reads return pins; writes to it load the output latch.
// - Output latch has its own address and reads back the latch.
// - Bits 6, 7 follow oscillator mode; non-port bits read 0 everywhere.
// - Pin 6 digital only in RC, internal or external clock I/O modes.
// - Pin 7 digital disabled in every external oscillator mode.
// - After reset pins 0,1,4,5 analog reading 0; pins 2,3 digital in.
// - Analog selection kills the digital input, not the digital output.
// - Reference output enabled disables pin 2 input and output.
// - Fault input comes from pin 5 or pin 7 by a select bit.
// - Pin 5 is input only, shared with reset and fault input.
// - Slow oscillator enabled forces its pins to inputs reading 0.
// - Slow oscillator pin placement follows its select bit.
// - Pins 0 and 1 feed interrupt, change and analog functions.
// - Serial port takes pins 2 and 3 over when enabled.
// - Pin 4 feeds counter 0 clock and analog functions.
`default_nettype none

package port_a_pkg;

	// ****************************************
	// Bus and register map
	// ****************************************
	localparam int          ADDR_W           = 12;
	localparam int          DATA_W           = 32;
	localparam logic [11:0] ADDR_PIN_LEVELS  = 12'h000;
	localparam logic [11:0] ADDR_DIRECTION   = 12'h004;
	localparam logic [11:0] ADDR_OUT_LATCH   = 12'h008;
	localparam logic [11:0] ADDR_CONFIG      = 12'h00c;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;

	// ****************************************
	// Configuration register fields
	// ****************************************
	localparam int CFG_OSC_LSB        = 0;
	localparam int CFG_FAULT_SEL      = 3;
	localparam int CFG_SLOW_SEL       = 4;
	localparam int CFG_SLOW_EN        = 5;
	localparam int CFG_COMPARATOR_REF_OUT_EN       = 6;
	localparam int CFG_SERIAL_EN      = 7;
	localparam int CFG_ANALOG_LSB     = 8;

	// ****************************************
	// Reset values and analog-capable mask
	// ****************************************
	localparam logic [7:0]  DIR_RESET        = 8'hff;
	localparam logic [7:0]  LATCH_RESET      = 8'h00;
	localparam logic [7:0]  ANALOG_RESET     = 8'h33;
	localparam logic [7:0]  CFG_LOW_RESET    = 8'h07;
	localparam logic [7:0]  ANALOG_CAPABLE   = 8'h73;

	// ****************************************
	// Main oscillator modes
	// ****************************************
	typedef enum logic [2:0] {
		OSC_CRYSTAL,
		OSC_HS_CRYSTAL,
		OSC_EXT_CLK_OUT,
		OSC_EXT_CLOCK_WITH_IO,
		OSC_RC_CLK_OUT,
		OSC_RC_OSC_WITH_IO,
		OSC_INT_CLK_OUT,
		OSC_INTERNAL_OSC_WITH_IO
	} osc_mode_e;

endpackage

`default_nettype wire
